// file: hw/edc_params.svh
// Purpose: Constants of the exception detect and cause unit.
// Assumes: 32-bit instruction words and addresses.
// Notes:   Cause codes, vectors and opcodes are plain defaults.
//
// How it works
// - Break instruction takes the common vector with the break code.
// - Restart register holds break address, or branch address in delay slot.
// - Delay slot flag set when faulting instruction is in a delay slot.
// - Break decode ignores instruction bits 25:6.
// - Undefined major, function-class or reg-immediate-class opcode is illegal.
// - 64-bit ops in 32-bit addressing are illegal outside kernel mode.
// - Unusable coprocessor traps; system coprocessor only when unusable in user mode.
// - Coprocessor trap records its code and the referenced unit number.
// - Float coprocessor trap takes common vector with float trap code.
// - Float condition held until software clears its status bit.
// - Eight interrupts, masked singly by mask field, globally by enable.
// - Interrupt records its code; vector select picks common or dedicated.
// - Pending field follows live request levels, no latching.
// - Two software interrupts, each cleared by writing zero.
// - Fetch address matching enabled instruction watch raises watch hit.
// - Load or store matching enabled data watch raises data watch hit.
// - User fetch above instruction limit raises user instruction limit code.
// - User data above data limit raises user data limit code.
// - Illegal and coprocessor traps save address with delay slot handling.
`ifndef EDC_PARAMS_SVH
`define EDC_PARAMS_SVH

`define EDC_CODE_INT        5'h00
`define EDC_CODE_WATCH      5'h17
`define EDC_CODE_BREAK      5'h09
`define EDC_CODE_ILLEGAL    5'h0A
`define EDC_CODE_COPROC     5'h0B
`define EDC_CODE_FLOAT      5'h0F
`define EDC_CODE_ULIM_I     5'h18
`define EDC_CODE_ULIM_D     5'h19
`define EDC_VEC_COMMON      32'h0000_0180
`define EDC_VEC_IRQ         32'h0000_0200
`define EDC_OP_FUNC_CLASS   6'h00
`define EDC_OP_REG_IMMEDIATE_CLASS_CLASS 6'h01
`define EDC_OP_COP0         6'h10
`define EDC_FN_BREAK        6'h0D
`define EDC_USER_TOP        32'h7FFF_FFFF
`define EDC_BRANCH_BACK     32'h0000_0004

`endif

// file: hw/edc_pkg.sv
// Purpose: Types of the exception detect and cause unit.
// Assumes: Used with edc_params.svh.
// Notes:   Privilege modes of the core.
`default_nettype none
package edc_pkg;
  typedef enum logic [1:0] {
    EDC_KERNEL = 2'h0,
    EDC_SUPER  = 2'h1,
    EDC_USER   = 2'h2
  } edc_mode_type;
endpackage
`default_nettype wire

// file: hw/edc_detect.sv
// Purpose: Detects exceptions of one instruction and records cause and restart.
// Assumes: One instruction presented per i_valid pulse; all inputs synchronous.
// Notes:   Outputs registered; o_take is a one-cycle pulse.
`include "edc_params.svh"
`default_nettype none
module edc_detect (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_valid,
  input  wire logic [31:0]           i_instr,
  input  wire logic [31:0]           i_pc,
  input  wire logic                  i_in_delay_slot,
  input  wire logic                  i_major_defined,
  input  wire logic                  i_func_defined,
  input  wire logic                  i_reg_immediate_class_defined,
  input  wire logic                  i_is_wide_op,
  input  wire logic                  i_wide_addr,
  input  wire edc_pkg::edc_mode_type i_mode,
  input  wire logic                  i_kernel_wide_addr_bit,
  input  wire logic                  i_is_coproc_op,
  input  wire logic [1:0]            i_coproc_num,
  input  wire logic [3:0]            i_coproc_usable,
  input  wire logic                  i_float_trap,
  input  wire logic                  i_float_status_clear,
  input  wire logic [5:0]            i_hw_irq,
  input  wire logic [7:0]            i_irq_mask,
  input  wire logic                  i_global_irq_enable,
  input  wire logic                  i_irq_vector_select,
  input  wire logic                  i_soft_irq_we,
  input  wire logic [1:0]            i_soft_irq_wdata,
  input  wire logic [31:0]           i_instr_watch_reg,
  input  wire logic                  i_instr_watch_en,
  input  wire logic [31:0]           i_data_watch_reg,
  input  wire logic                  i_data_watch_rd_en,
  input  wire logic                  i_data_watch_wr_en,
  input  wire logic                  i_is_load,
  input  wire logic                  i_is_store,
  input  wire logic [31:0]           i_data_addr,
  input  wire logic [31:0]           i_instr_limit_reg,
  input  wire logic [31:0]           i_data_limit_reg,
  output logic                       o_take,
  output logic [31:0]                o_vector,
  output logic [4:0]                 o_cause_code,
  output logic [31:0]                o_restart_pc_reg,
  output logic                       o_delay_slot_flag,
  output logic [1:0]                 o_coproc_err,
  output logic                       o_instr_watch_hit,
  output logic                       o_data_watch_hit,
  output logic [7:0]                 o_pending_irq_field,
  output logic                       o_float_pending
);
  import edc_pkg::*;

  // ------------------------------------------------------------
  // Condition detection
  // ------------------------------------------------------------
  logic [1:0]  soft_irq;
  logic        float_hold;
  logic [7:0]  live_irq;
  logic        is_break;
  logic        ill_op;
  logic        cop_fault;
  logic        irq_fire;
  logic        instr_watch_reg_fire;
  logic        data_watch_reg_fire;
  logic        ilim_fire;
  logic        dlim_fire;
  logic        next_take;
  logic [4:0]  next_code;
  logic [31:0] next_vector;
  logic        next_iw;
  logic        next_dw;

  assign live_irq = {i_hw_irq, soft_irq};
  // Opcode and function fields only; bits 25:6 are a free code
  assign is_break = (i_instr[31:26] == `EDC_OP_FUNC_CLASS) &&
                    (i_instr[5:0] == `EDC_FN_BREAK);
  assign ill_op = !i_major_defined ||
                  ((i_instr[31:26] == `EDC_OP_FUNC_CLASS) && !i_func_defined) ||
                  ((i_instr[31:26] == `EDC_OP_REG_IMMEDIATE_CLASS_CLASS) && !i_reg_immediate_class_defined) ||
                  (i_is_wide_op && !i_wide_addr && (i_mode != EDC_KERNEL));
  assign cop_fault = i_is_coproc_op && !i_coproc_usable[i_coproc_num] &&
                     ((i_coproc_num != 2'h0) || (i_mode == EDC_USER));
  assign irq_fire = i_global_irq_enable && |(live_irq & i_irq_mask);
  assign instr_watch_reg_fire = i_instr_watch_en && (i_pc == i_instr_watch_reg);
  assign data_watch_reg_fire = (i_data_addr == i_data_watch_reg) &&
                       ((i_is_load && i_data_watch_rd_en) ||
                        (i_is_store && i_data_watch_wr_en));
  assign ilim_fire = (i_mode == EDC_USER) && (i_pc <= `EDC_USER_TOP) &&
                     (i_pc > i_instr_limit_reg);
  assign dlim_fire = (i_mode == EDC_USER) && (i_is_load || i_is_store) &&
                     (i_data_addr <= `EDC_USER_TOP) &&
                     (i_data_addr > i_data_limit_reg);

  // ------------------------------------------------------------
  // Fixed priority select
  // ------------------------------------------------------------
  always_comb begin
    next_take   = i_valid;
    next_vector = `EDC_VEC_COMMON;
    next_code   = `EDC_CODE_INT;
    next_iw     = 1'b0;
    next_dw     = 1'b0;
    // Interrupt first, then fetch-side, decode, execute, memory
    if (irq_fire) begin
      next_code = `EDC_CODE_INT;
      if (i_irq_vector_select) begin
        next_vector = `EDC_VEC_IRQ;
      end
    end else if (instr_watch_reg_fire) begin
      next_code = `EDC_CODE_WATCH;
      next_iw   = 1'b1;
    end else if (ilim_fire) begin
      next_code = `EDC_CODE_ULIM_I;
    end else if (cop_fault) begin
      next_code = `EDC_CODE_COPROC;
    end else if (ill_op) begin
      next_code = `EDC_CODE_ILLEGAL;
    end else if (is_break) begin
      next_code = `EDC_CODE_BREAK;
    end else if (float_hold) begin
      next_code = `EDC_CODE_FLOAT;
    end else if (data_watch_reg_fire) begin
      next_code = `EDC_CODE_WATCH;
      next_dw   = 1'b1;
    end else if (dlim_fire) begin
      next_code = `EDC_CODE_ULIM_D;
    end else begin
      next_take = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Software interrupts and float condition
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      soft_irq <= 2'h0;
    end else if (i_soft_irq_we) begin
      soft_irq <= i_soft_irq_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      float_hold <= 1'b0;
    end else if (i_float_trap) begin
      float_hold <= 1'b1;
    end else if (i_float_status_clear) begin
      float_hold <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pending_irq_field <= 8'h00;
      o_float_pending     <= 1'b0;
    end else begin
      o_pending_irq_field <= live_irq;
      o_float_pending     <= i_float_trap || (float_hold && !i_float_status_clear);
    end
  end

  // ------------------------------------------------------------
  // Cause recording
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_take <= 1'b0;
    end else begin
      o_take <= next_take;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_vector          <= `EDC_VEC_COMMON;
      o_cause_code      <= `EDC_CODE_INT;
      o_restart_pc_reg  <= 32'h0000_0000;
      o_delay_slot_flag <= 1'b0;
      o_coproc_err      <= 2'h0;
      o_instr_watch_hit <= 1'b0;
      o_data_watch_hit  <= 1'b0;
    end else if (next_take) begin
      o_vector          <= next_vector;
      o_cause_code      <= next_code;
      o_restart_pc_reg  <= i_in_delay_slot ? (i_pc - `EDC_BRANCH_BACK)
                                           : i_pc;
      o_delay_slot_flag <= i_in_delay_slot;
      o_coproc_err      <= i_coproc_num;
      o_instr_watch_hit <= next_iw;
      o_data_watch_hit  <= next_dw;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_break_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && is_break && !irq_fire && !instr_watch_reg_fire && !ilim_fire && !cop_fault &&
    !ill_op |=> o_take && o_cause_code == `EDC_CODE_BREAK && o_vector == `EDC_VEC_COMMON)
    else $error("break not reported");
  a_restart_slot: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    next_take && i_in_delay_slot |=> o_restart_pc_reg == $past(i_pc) - 32'h4)
    else $error("restart address wrong in delay slot");
  a_slot_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    next_take |=> o_delay_slot_flag == $past(i_in_delay_slot))
    else $error("delay slot flag wrong");
  a_wide_kernel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_mode == EDC_KERNEL && i_major_defined && i_func_defined && i_reg_immediate_class_defined
    |-> !ill_op)
    else $error("kernel wide op refused");
  a_float_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_float_trap ##1 !i_float_status_clear [*2] |-> float_hold)
    else $error("float condition lost");
  a_irq_masked: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_global_irq_enable |-> !irq_fire)
    else $error("interrupt passed global mask");
  a_irq_vector: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && irq_fire && i_irq_vector_select |=> o_vector == `EDC_VEC_IRQ)
    else $error("dedicated vector not used");
  a_pending_live: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> o_pending_irq_field[7:2] == $past(i_hw_irq))
    else $error("pending field latched");
  a_soft_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_soft_irq_we && !i_soft_irq_wdata[0] |=> ##1 !o_pending_irq_field[0])
    else $error("soft interrupt not cleared");
  a_instr_watch_reg_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && instr_watch_reg_fire && !irq_fire |=> o_instr_watch_hit && !o_data_watch_hit)
    else $error("watch hit bit wrong");
  a_one_take: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take |-> !(o_instr_watch_hit && o_data_watch_hit))
    else $error("two causes reported");

  // ------------------------------------------------------------
  // Per cause checks
  // ------------------------------------------------------------
  a_illegal_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && ill_op && !irq_fire && !instr_watch_reg_fire && !ilim_fire && !cop_fault
    |=> o_take && o_cause_code == `EDC_CODE_ILLEGAL && o_vector == `EDC_VEC_COMMON)
    else $error("illegal opcode not reported");
  a_major_illegal: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_major_defined
    |-> ill_op)
    else $error("undefined major opcode passed");
  a_user_wide: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_is_wide_op && !i_wide_addr && i_mode != EDC_KERNEL
    |-> ill_op)
    else $error("wide op passed outside kernel");
  a_cop_other: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_is_coproc_op && !i_coproc_usable[i_coproc_num] && i_coproc_num != 2'h0
    |-> cop_fault)
    else $error("unusable coprocessor passed");
  a_cop_user: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_is_coproc_op && i_coproc_num == 2'h0 && !i_coproc_usable[0] && i_mode == EDC_USER
    |-> cop_fault)
    else $error("system coprocessor passed in user mode");
  a_cop_record: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && cop_fault && !irq_fire && !instr_watch_reg_fire && !ilim_fire
    |=> o_take && o_cause_code == `EDC_CODE_COPROC && o_coproc_err == $past(i_coproc_num))
    else $error("coprocessor trap record wrong");
  a_float_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && float_hold && !irq_fire && !instr_watch_reg_fire && !ilim_fire && !cop_fault &&
    !ill_op && !is_break |=> o_take && o_cause_code == `EDC_CODE_FLOAT)
    else $error("float trap not reported");
  a_float_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_float_trap
    |=> float_hold)
    else $error("float trap not held");
  a_float_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    float_hold && i_float_status_clear && !i_float_trap
    |=> !float_hold && !o_float_pending)
    else $error("float condition not cleared");
  a_irq_common: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && irq_fire && !i_irq_vector_select
    |=> o_take && o_cause_code == `EDC_CODE_INT && o_vector == `EDC_VEC_COMMON)
    else $error("interrupt record wrong");
  a_pending_soft: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1
    |=> o_pending_irq_field[1:0] == $past(soft_irq))
    else $error("soft pending bits latched");
  a_soft_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_soft_irq_we && i_soft_irq_wdata[1]
    |=> ##1 o_pending_irq_field[1])
    else $error("soft interrupt not set");
  a_instr_watch_reg_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_instr_watch_en
    |-> !instr_watch_reg_fire)
    else $error("disabled instruction watch fired");
  a_data_watch_reg_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && data_watch_reg_fire && !irq_fire && !instr_watch_reg_fire && !ilim_fire && !cop_fault &&
    !ill_op && !is_break && !float_hold
    |=> o_take && o_data_watch_hit && !o_instr_watch_hit && o_cause_code == `EDC_CODE_WATCH)
    else $error("data watch hit wrong");
  a_ilim_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && ilim_fire && !irq_fire && !instr_watch_reg_fire
    |=> o_take && o_cause_code == `EDC_CODE_ULIM_I && o_vector == `EDC_VEC_COMMON)
    else $error("instruction limit not reported");
  a_lim_user_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_mode != EDC_USER
    |-> !ilim_fire && !dlim_fire)
    else $error("limit fired outside user mode");
  a_dlim_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_valid && dlim_fire && !irq_fire && !instr_watch_reg_fire && !ilim_fire && !cop_fault &&
    !ill_op && !is_break && !float_hold && !data_watch_reg_fire
    |=> o_take && o_cause_code == `EDC_CODE_ULIM_D && o_vector == `EDC_VEC_COMMON)
    else $error("data limit not reported");
  a_restart_plain: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    next_take && !i_in_delay_slot
    |=> o_restart_pc_reg == $past(i_pc))
    else $error("restart address wrong");
  a_no_take_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_valid
    |=> !o_take)
    else $error("take without instruction");
  a_common_vec: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take && o_cause_code != `EDC_CODE_INT
    |-> o_vector == `EDC_VEC_COMMON)
    else $error("non interrupt used dedicated vector");

  // ------------------------------------------------------------
  // Per interrupt line checks
  // ------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_irq_line
    a_irq_line: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_global_irq_enable && i_irq_mask[g] && live_irq[g]
      |-> irq_fire)
      else $error("enabled interrupt line ignored");
    a_irq_line_mask: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (live_irq & i_irq_mask) == 8'h00
      |-> !irq_fire)
      else $error("masked interrupt line fired");
  end

  c_break: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take && o_cause_code == `EDC_CODE_BREAK && o_delay_slot_flag);
  c_irq: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take && o_vector == `EDC_VEC_IRQ);
  c_cop: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take && o_cause_code == `EDC_CODE_COPROC);
  c_dlim: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take && o_cause_code == `EDC_CODE_ULIM_D);
  c_data_watch_reg: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_take && o_data_watch_hit);
endmodule // edc_detect
`default_nettype wire

// file: verification/edc_irq_src.sv
// Purpose: Model of the external interrupt sources on the hardware pins.
// Assumes: Raise and resolve requests are one-cycle pulses.
// Notes:   A pin stays asserted until its condition is resolved.
`default_nettype none
module edc_irq_src (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [5:0] i_raise,
  input  wire logic [5:0] i_resolve,
  output var  logic [5:0] o_hw_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_hw_irq <= 6'h00;
    end else begin
      o_hw_irq <= (o_hw_irq | i_raise) & ~i_resolve;
    end
  end
endmodule  // edc_irq_src
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Random self-checking bench for the exception detect and cause unit.
// Assumes: Inputs change at the falling edge; a reference model predicts each edge.
// Notes:   Request changes are followed by quiet cycles before instructions run.
`include "edc_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import edc_pkg::*;
  logic         i_sys_clk = 1'b0;
  logic         i_rst = 1'b1;
  logic         i_valid, i_in_delay_slot, i_major_defined, i_func_defined, i_reg_immediate_class_defined;
  logic         i_is_wide_op, i_wide_addr, i_kernel_wide_addr_bit, i_is_coproc_op;
  logic         i_float_trap, i_float_status_clear, i_global_irq_enable, i_irq_vector_select;
  logic         i_soft_irq_we, i_instr_watch_en, i_data_watch_rd_en, i_data_watch_wr_en;
  logic         i_is_load, i_is_store, o_take, o_delay_slot_flag, o_instr_watch_hit;
  logic         o_data_watch_hit, o_float_pending, e_take, e_ds, e_fp, k_cp, k_iw, k_dw;
  logic [1:0]   i_coproc_num, i_soft_irq_wdata, o_coproc_err, e_cp, sw_m;
  logic [3:0]   i_coproc_usable;
  logic [4:0]   o_cause_code, e_cause;
  logic [5:0]   i_hw_irq, i_raise, i_resolve, hw_m;
  logic [7:0]   i_irq_mask, o_pending_irq_field;
  logic [31:0]  i_instr, i_pc, i_instr_watch_reg, i_data_watch_reg, i_data_addr, e_vec;
  logic [31:0]  i_instr_limit_reg, i_data_limit_reg, o_vector, o_restart_pc_reg, e_rpc;
  edc_mode_type i_mode;
  integer       seed = 14862;
  int           num_errors = 0;
  int           num_checks = 0;
  int           calm = 0;
  int           cyc = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;
  edc_irq_src u_irq (.i_sys_clk, .i_rst, .i_raise, .i_resolve, .o_hw_irq(i_hw_irq));
  edc_detect u_dut (.*);

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Level changes come as events; instructions wait three quiet cycles after one
  task automatic step;
    logic [31:0] r, q, s;
    logic        ev, irq, ill, iwh, dwh;
    logic [4:0]  code;
    r = $random(seed);
    q = $random(seed);
    s = $random(seed);
    ev = r[2:0] == 3'h0 || cyc == 0;
    calm = ev ? 0 : calm + 1;
    {i_raise, i_resolve, i_soft_irq_we, i_float_trap, i_float_status_clear} = '0;
    if (ev) begin
      {i_raise, i_resolve, i_soft_irq_we, i_soft_irq_wdata} = q[14:0];
      {i_float_trap, i_float_status_clear, i_irq_mask, i_irq_vector_select} = q[25:15];
      i_global_irq_enable = &q[27:26];
      hw_m = (hw_m | i_raise) & ~i_resolve;
      if (i_soft_irq_we) sw_m = i_soft_irq_wdata;
      e_fp = i_float_trap | (e_fp & ~i_float_status_clear);
    end
    i_valid = calm >= 3 && r[3];
    i_instr = $random(seed);
    i_instr[31:26] = r[4] ? {5'h00, r[5]} : r[11:6];
    if (r[12]) i_instr[5:0] = `EDC_FN_BREAK;
    {i_major_defined, i_func_defined, i_reg_immediate_class_defined} = r[15:13] | {3{r[16]}};
    {i_in_delay_slot, i_is_wide_op, i_wide_addr, i_is_coproc_op} = r[20:17];
    {i_coproc_num, i_coproc_usable, i_kernel_wide_addr_bit} = r[27:21];
    i_mode = r[28] ? EDC_USER : (r[29] ? EDC_SUPER : EDC_KERNEL);
    if (i_coproc_num == 2'h0 && !r[28]) i_coproc_usable[0] = 1'b1;
    i_pc = {r[30], 26'h0, s[2:0], 2'h0};
    {i_is_load, i_is_store, i_data_watch_rd_en, i_data_watch_wr_en, i_instr_watch_en} = s[7:3];
    i_is_store = i_is_store & ~i_is_load;
    i_data_addr = (i_is_load | i_is_store) ? {s[8], 26'h0, s[11:9], 2'h0} : 32'h0;
    i_instr_watch_reg = {27'h0, s[14:12], 2'h0};
    i_data_watch_reg = {27'h0, s[17:15], 2'h0};
    i_instr_limit_reg = {27'h0, s[20:18], 2'h0};
    i_data_limit_reg = {27'h0, s[23:21], 2'h0};
    irq = |({hw_m, sw_m} & i_irq_mask) & i_global_irq_enable;
    ill = !i_major_defined || (i_instr[31:26] == `EDC_OP_FUNC_CLASS && !i_func_defined)
      || (i_instr[31:26] == `EDC_OP_REG_IMMEDIATE_CLASS_CLASS && !i_reg_immediate_class_defined)
      || (i_is_wide_op && !i_wide_addr && i_mode != EDC_KERNEL);
    iwh = i_instr_watch_en && i_pc == i_instr_watch_reg;
    dwh = ((i_is_load && i_data_watch_rd_en) || (i_is_store && i_data_watch_wr_en))
      && i_data_addr == i_data_watch_reg;
    code = 5'h1F;
    if (irq) code = `EDC_CODE_INT;
    else if (iwh) code = `EDC_CODE_WATCH;
    else if (r[28] && !i_pc[31] && i_pc > i_instr_limit_reg) code = `EDC_CODE_ULIM_I;
    else if (i_is_coproc_op && !i_coproc_usable[i_coproc_num]) code = `EDC_CODE_COPROC;
    else if (ill) code = `EDC_CODE_ILLEGAL;
    else if (i_instr[31:26] == 6'h00 && i_instr[5:0] == `EDC_FN_BREAK) code = `EDC_CODE_BREAK;
    else if (e_fp) code = `EDC_CODE_FLOAT;
    else if (dwh) code = `EDC_CODE_WATCH;
    else if (r[28] && !i_data_addr[31] && i_data_addr > i_data_limit_reg) code = `EDC_CODE_ULIM_D;
    e_take = i_valid && code != 5'h1F;
    if (e_take) begin
      e_vec = (irq && i_irq_vector_select) ? `EDC_VEC_IRQ : `EDC_VEC_COMMON;
      e_cause = code;
      e_rpc = i_in_delay_slot ? i_pc - `EDC_BRANCH_BACK : i_pc;
      e_ds = i_in_delay_slot;
      e_cp = i_coproc_num;
      k_cp = code == `EDC_CODE_COPROC;
      k_iw = code == `EDC_CODE_WATCH && iwh;
      k_dw = code == `EDC_CODE_WATCH && !iwh;
    end
  endtask

  task automatic check;
    cmp(o_take, e_take);
    cmp(o_vector, e_vec);
    cmp(o_cause_code, e_cause);
    cmp(o_restart_pc_reg, e_rpc);
    cmp(o_delay_slot_flag, e_ds);
    cmp(o_float_pending, e_fp);
    if (k_cp) cmp(o_coproc_err, e_cp);
    if (k_iw) cmp(o_instr_watch_hit, 1'b1);
    if (k_dw) cmp(o_data_watch_hit, 1'b1);
    if (calm >= 3) cmp(o_pending_irq_field, {hw_m, sw_m});
  endtask

  initial begin
    step();
    {e_take, e_ds, e_fp, e_cause, e_rpc, hw_m, sw_m, k_cp, k_iw, k_dw} = '0;
    e_vec = `EDC_VEC_COMMON;
    repeat (6) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (4000) begin
      step();
      @(negedge i_sys_clk);
      check();
    end
    close_out();
  end

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end
endmodule  // testbench
`default_nettype wire
